// ===== rtl/rmps_pkg.sv
// Constants and types for the radio parameter set and sleep controller
// Contract
// - Level query returns one byte, 0x06 to 0x36
// - Larger level reading means stronger reception
// - Shared line config accepts 0-2, default 0
// - RTS and binary programming need line config
// - Stop bit select: 0 one, 1 two
// - Serial number upper word is read-only
// - Serial number lower word is read-only
// - Sleep selection accepts 0, 1, 3-8 only
// - Cyclic wake every 0.5 to 16 seconds
// - Selection 0 after reset: always awake
// - Initializer seen while listening: sync, then receive
// - No initializer: back to sleep, keep cycling
// - Idle time 0x10-0xFFFF, default 0x64, 100 ms
// - Sleep after programmed idle time elapses
// - Idle timer acts only in cyclic sleep
package rmps_pkg;
   localparam logic [11:0] OFS_SLEEP_SEL = 12'h004;
   localparam logic [11:0] OFS_IDLE      = 12'h008;
   localparam logic [11:0] OFS_LINE_CFG  = 12'h058;
   localparam logic [11:0] OFS_LEVEL     = 12'h070;
   localparam logic [11:0] OFS_SN_UPPER  = 12'h094;
   localparam logic [11:0] OFS_SN_LOWER  = 12'h098;
   localparam logic [11:0] OFS_STOP      = 12'h0D8;
   localparam logic [11:0] OFS_STATUS    = 12'h0FC;

   localparam logic [3:0]  RST_SLEEP_SEL = 4'h0;
   localparam logic [15:0] RST_IDLE      = 16'h0064;
   localparam logic [1:0]  RST_LINE_CFG  = 2'h0;
   localparam logic        RST_STOP      = 1'b0;
   localparam logic [7:0]  RST_LEVEL     = 8'h06;

   localparam logic [7:0]  LEVEL_MIN     = 8'h06;
   localparam logic [7:0]  LEVEL_MAX     = 8'h36;
   localparam logic [15:0] IDLE_MIN      = 16'h0010;
   localparam logic [1:0]  LINE_OFF      = 2'h0;
   localparam logic [1:0]  LINE_BINPROG  = 2'h1;
   localparam logic [1:0]  LINE_RTS      = 2'h2;
   localparam logic [3:0]  SEL_OFF       = 4'h0;
   localparam logic [3:0]  SEL_PIN       = 4'h1;
   localparam logic [3:0]  SEL_CYC_MIN   = 4'h3;
   localparam logic [3:0]  SEL_CYC_MAX   = 4'h8;

   // Serial number words, arbitrary values
   localparam logic [15:0] SN_UPPER      = 16'h00A5;
   localparam logic [15:0] SN_LOWER      = 16'h5A01;

   localparam int          CLK_PERIOD_NS = 100;
   localparam int          TICK_MS       = 100;
   localparam int          TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [15:0] CYC_BASE_TICKS = 16'h0005;
   localparam logic [15:0] LISTEN_TICKS  = 16'h0001;

   localparam int          STAT_STATE_LSB = 0;
   localparam int          STAT_REJ_BIT   = 4;

   typedef enum logic [1:0] {
      RMPS_ACTIVE,
      RMPS_SLEEP,
      RMPS_LISTEN,
      RMPS_SYNC
   } rmps_state_t;
endpackage

// ===== rtl/rmps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rmps_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // One chain per bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            q[i]      <= 1'b0;
         end else begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
         end
      end
   end
endmodule

// ===== rtl/rmps_tick.sv
// Free-running divider giving one pulse per tick period
`timescale 1ns/1ps
module rmps_tick #(
   parameter int CYCLES = 1000000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      tick
);
   logic [31:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h0000_0000;
         tick  <= 1'b0;
      end else if (cnt_q == 32'(CYCLES - 1)) begin
         cnt_q <= 32'h0000_0000;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
         tick  <= 1'b0;
      end
   end
endmodule

// ===== rtl/rmps_top.sv
// Radio parameter set with AHB-Lite access and sleep controller
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rmps_top #(
   parameter int TICK_CYCLES = rmps_pkg::TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic [7:0]  rx_level,
   input  wire logic        rx_level_valid,
   input  wire logic        tx_active,
   input  wire logic        rx_active,
   input  wire logic        init_detect,
   input  wire logic        init_done,
   input  wire logic        pin_sleep,
   input  wire logic        shared_input_line,
   output logic             low_power_q,
   output logic             listen_q,
   output logic             rx_start_q,
   output logic             stop_two_q,
   output logic             rts_hold_q,
   output logic             bin_prog_q
);
   import rmps_pkg::*;

   logic        pin_sleep_s;
   logic        line_s;
   logic        tick;
   logic        rd_pend_q;
   logic        wr_pend_q;
   logic [11:0] addr_q;
   logic [3:0]  sleep_sel_q;
   logic [15:0] idle_q;
   logic [1:0]  line_cfg_q;
   logic        stop_q;
   logic [7:0]  level_q;
   logic        rej_q;
   logic        rej_set;
   logic [31:0] rd_val;
   logic        cyclic;
   logic [15:0] period;
   rmps_state_t state_q;
   rmps_state_t state_d;
   logic [15:0] tcnt_q;
   logic [15:0] tcnt_d;

   rmps_sync #(
      .W (2)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({pin_sleep, shared_input_line}),
      .q     ({pin_sleep_s, line_s})
   );

   rmps_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .tick  (tick)
   );

   // Bus address phase capture; reads take one wait state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         addr_q    <= 12'h000;
      end else begin
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
         if (hsel && htrans[1] && hready) begin
            rd_pend_q <= !hwrite;
            wr_pend_q <= hwrite;
            addr_q    <= haddr[11:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         if (hsel && htrans[1] && hready && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend_q) begin
            hreadyout <= 1'b1;
            hrdata    <= rd_val;
         end
      end
   end

   // Read mux, unmapped reads as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (addr_q)
         OFS_SLEEP_SEL: rd_val[3:0] = sleep_sel_q;
         OFS_IDLE:      rd_val[15:0] = idle_q;
         OFS_LINE_CFG:  rd_val[1:0] = line_cfg_q;
         OFS_LEVEL:     rd_val[7:0] = level_q;
         OFS_SN_UPPER:  rd_val[15:0] = SN_UPPER;
         OFS_SN_LOWER:  rd_val[15:0] = SN_LOWER;
         OFS_STOP:      rd_val[0] = stop_q;
         OFS_STATUS: begin
            rd_val[STAT_STATE_LSB +: 2] = state_q;
            rd_val[STAT_REJ_BIT]        = rej_q;
         end
         default:       rd_val = 32'h0000_0000;
      endcase
   end

   always_comb begin
      rej_set = 1'b0;
      if (wr_pend_q) begin
         case (addr_q)
            OFS_SLEEP_SEL: rej_set = (hwdata > 32'(SEL_CYC_MAX)) || (hwdata == 32'(4'h2));
            OFS_IDLE:      rej_set = (hwdata > 32'h0000_FFFF) || (hwdata < 32'(IDLE_MIN));
            OFS_LINE_CFG:  rej_set = hwdata > 32'(LINE_RTS);
            OFS_STOP:      rej_set = hwdata > 32'h0000_0001;
            default:       rej_set = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_cfg_q <= RST_LINE_CFG;
      end else if (wr_pend_q && addr_q == OFS_LINE_CFG && !rej_set) begin
         line_cfg_q <= hwdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_q <= RST_STOP;
      end else if (wr_pend_q && addr_q == OFS_STOP && !rej_set) begin
         stop_q <= hwdata[0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sel_q <= RST_SLEEP_SEL;
      end else if (wr_pend_q && addr_q == OFS_SLEEP_SEL && !rej_set) begin
         sleep_sel_q <= hwdata[3:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_q <= RST_IDLE;
      end else if (wr_pend_q && addr_q == OFS_IDLE && !rej_set) begin
         idle_q <= hwdata[15:0];
      end
   end

   // Sticky reject flag, set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rej_q <= 1'b0;
      end else if (rej_set) begin
         rej_q <= 1'b1;
      end else if (wr_pend_q && addr_q == OFS_STATUS && hwdata[STAT_REJ_BIT]) begin
         rej_q <= 1'b0;
      end
   end

   // Clamp level so larger is stronger
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= RST_LEVEL;
      end else if (rx_level_valid) begin
         if (rx_level > LEVEL_MAX) begin
            level_q <= LEVEL_MAX;
         end else if (rx_level < LEVEL_MIN) begin
            level_q <= LEVEL_MIN;
         end else begin
            level_q <= rx_level;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rts_hold_q <= 1'b0;
         bin_prog_q <= 1'b0;
         stop_two_q <= 1'b0;
      end else begin
         rts_hold_q <= (line_cfg_q == LINE_RTS) && line_s;
         bin_prog_q <= (line_cfg_q == LINE_BINPROG) && line_s;
         stop_two_q <= stop_q;
      end
   end

   assign cyclic = (sleep_sel_q >= SEL_CYC_MIN) && (sleep_sel_q <= SEL_CYC_MAX);
   // Period doubles from 0.5 s per step
   assign period = cyclic ? (CYC_BASE_TICKS << (sleep_sel_q - SEL_CYC_MIN)) : CYC_BASE_TICKS;

   // Sleep sequencing
   always_comb begin
      state_d = state_q;
      tcnt_d  = tcnt_q;
      if (sleep_sel_q == SEL_OFF) begin
         state_d = RMPS_ACTIVE;
         tcnt_d  = 16'h0000;
      end else if (sleep_sel_q == SEL_PIN) begin
         state_d = pin_sleep_s ? RMPS_SLEEP : RMPS_ACTIVE;
         tcnt_d  = 16'h0000;
      end else begin
         case (state_q)
            RMPS_ACTIVE: begin
               if (tx_active || rx_active) begin
                  tcnt_d = 16'h0000;
               end else if (tcnt_q >= idle_q) begin
                  state_d = RMPS_SLEEP;
                  tcnt_d  = 16'h0000;
               end else if (tick) begin
                  tcnt_d = tcnt_q + 16'h0001;
               end
            end
            RMPS_SLEEP: begin
               if (tick) begin
                  tcnt_d = tcnt_q + 16'h0001;
                  if (tcnt_q + 16'h0001 >= period) begin
                     state_d = RMPS_LISTEN;
                     tcnt_d  = 16'h0000;
                  end
               end
            end
            RMPS_LISTEN: begin
               if (init_detect) begin
                  state_d = RMPS_SYNC;
                  tcnt_d  = 16'h0000;
               end else if (tick) begin
                  tcnt_d = tcnt_q + 16'h0001;
                  if (tcnt_q + 16'h0001 >= LISTEN_TICKS) begin
                     state_d = RMPS_SLEEP;
                     tcnt_d  = 16'h0000;
                  end
               end
            end
            RMPS_SYNC: begin
               if (init_done) begin
                  state_d = RMPS_ACTIVE;
                  tcnt_d  = 16'h0000;
               end
            end
            default: begin
               state_d = RMPS_ACTIVE;
               tcnt_d  = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= RMPS_ACTIVE;
         tcnt_q  <= 16'h0000;
      end else begin
         state_q <= state_d;
         tcnt_q  <= tcnt_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_power_q <= 1'b0;
         listen_q    <= 1'b0;
         rx_start_q  <= 1'b0;
      end else begin
         low_power_q <= state_d == RMPS_SLEEP;
         listen_q    <= state_d == RMPS_LISTEN;
         rx_start_q  <= (state_q == RMPS_SYNC) && (state_d == RMPS_ACTIVE);
      end
   end

   a_level_range: assert property (
      @(posedge clk) disable iff (!rst_n)
      (level_q >= LEVEL_MIN) && (level_q <= LEVEL_MAX))
      else $error("level reading left its range");

   a_level_strong: assert property (
      @(posedge clk) disable iff (!rst_n)
      rx_level_valid && (rx_level >= LEVEL_MAX) |=> level_q == LEVEL_MAX)
      else $error("strong signal not shown as maximum");

   a_line_gate: assert property (
      @(posedge clk) disable iff (!rst_n)
      !(rts_hold_q && $past(line_cfg_q) != LINE_RTS) && !(bin_prog_q && $past(line_cfg_q) != LINE_BINPROG))
      else $error("shared line acted without its function");

   a_sel_reject: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_pend_q && addr_q == OFS_SLEEP_SEL && hwdata == 32'h0000_0002 |=> $stable(sleep_sel_q))
      else $error("illegal sleep selection accepted");

   a_idle_floor: assert property (
      @(posedge clk) disable iff (!rst_n)
      idle_q >= IDLE_MIN)
      else $error("idle time below its floor");

   a_off_awake: assert property (
      @(posedge clk) disable iff (!rst_n)
      sleep_sel_q == SEL_OFF |=> !low_power_q && !listen_q)
      else $error("low power while sleep disabled");

   a_idle_restart: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == RMPS_ACTIVE && (tx_active || rx_active) |=> tcnt_q == 16'h0000)
      else $error("activity did not restart idle count");

   a_sync_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_q == RMPS_LISTEN && init_detect && cyclic && !wr_pend_q |=> state_q == RMPS_SYNC)
      else $error("initializer missed while listening");

   a_rd_answer: assert property (
      @(posedge clk) disable iff (!rst_n)
      rd_pend_q |=> hreadyout && $past(!hreadyout))
      else $error("read answer not given after one wait");
endmodule

// ===== test/rmps_radio_model.sv
// Radio-side model: packet levels, activity and wake-up initializer
`timescale 1ns/1ps
module rmps_radio_model (
   input  wire logic       clk,
   output logic      [7:0] rx_level,
   output logic            rx_level_valid,
   output logic            tx_active,
   output logic            rx_active,
   output logic            init_detect,
   output logic            init_done
);
   initial begin
      rx_level       = 8'h00;
      rx_level_valid = 1'b0;
      tx_active      = 1'b0;
      rx_active      = 1'b0;
      init_detect    = 1'b0;
      init_done      = 1'b0;
   end

   // One packet, then the level bus shows junk
   task automatic packet(input logic [7:0] lv);
      @(posedge clk);
      rx_level       <= lv;
      rx_level_valid <= 1'b1;
      rx_active      <= 1'b1;
      @(posedge clk);
      rx_level       <= ~lv;
      rx_level_valid <= 1'b0;
      rx_active      <= 1'b0;
   endtask

   task automatic busy(input logic t, input logic r);
      @(posedge clk);
      tx_active <= t;
      rx_active <= r;
   endtask

   task automatic detect;
      @(posedge clk);
      init_detect <= 1'b1;
   endtask

   // Initializer has run its full length
   task automatic done;
      @(posedge clk);
      init_detect <= 1'b0;
      init_done   <= 1'b1;
      @(posedge clk);
      init_done <= 1'b0;
   endtask
endmodule

// ===== test/rmps_top_tb_top.sv
// Self-checking bench for the parameter set and sleep controller
`timescale 1ns/1ps
module rmps_top_tb_top;
   import rmps_pkg::*;
   logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, pin_sleep, line_in;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  rx_level;
   logic        rx_level_valid, tx_active, rx_active, init_detect, init_done;
   logic        low_power_q, listen_q, rx_start_q, stop_two_q, rts_hold_q, bin_prog_q;
   logic [44:0] rows [0:19];
   int          miscompares, compares, cyc, n;

   rmps_top #(.TICK_CYCLES(10)) i_rmps_top (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .rx_level(rx_level), .rx_level_valid(rx_level_valid), .tx_active(tx_active),
      .rx_active(rx_active), .init_detect(init_detect), .init_done(init_done), .pin_sleep(pin_sleep),
      .shared_input_line(line_in), .low_power_q(low_power_q), .listen_q(listen_q),
      .rx_start_q(rx_start_q), .stop_two_q(stop_two_q), .rts_hold_q(rts_hold_q), .bin_prog_q(bin_prog_q));

   rmps_radio_model i_rmps_radio_model (
      .clk(clk), .rx_level(rx_level), .rx_level_valid(rx_level_valid), .tx_active(tx_active),
      .rx_active(rx_active), .init_detect(init_detect), .init_done(init_done));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic end_of_test;
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chkb(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Single AHB-Lite word transfer, waits on ready
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'b010;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask

   task automatic level_chk(input logic [7:0] lv, input logic [7:0] e);
      i_rmps_radio_model.packet(lv);
      bus(1'b0, OFS_LEVEL, 32'h0000_0000, rd);
      chk("level", {24'h00_0000, e}, rd);
   endtask

   // Edges until a condition holds, capped at lim
   task automatic wait_on(input int which, input int lim, output int cnt);
      logic hit;
      cnt = 0;
      hit = 1'b0;
      while (!hit && cnt < lim) begin
         @(posedge clk);
         cnt++;
         case (which)
            0: hit = (low_power_q === 1'b1);
            1: hit = (listen_q === 1'b1);
            2: hit = (rx_start_q === 1'b1);
            default: hit = (listen_q === 1'b0);
         endcase
      end
   endtask

   initial begin
      rst_n   <= 1'b0;
      hsel    <= 1'b0;
      haddr   <= 32'h0000_0000;
      htrans  <= 2'b00;
      hwrite  <= 1'b0;
      hsize   <= 3'b010;
      hwdata  <= 32'h0000_0000;
      pin_sleep <= 1'b0;
      line_in <= 1'b0;
      rows[0]  = {1'b0, OFS_SLEEP_SEL, 16'h0000, 16'h0000};
      rows[1]  = {1'b0, OFS_IDLE, 16'h0000, 16'h0064};
      rows[2]  = {1'b0, OFS_LINE_CFG, 16'h0000, 16'h0000};
      rows[3]  = {1'b0, OFS_STOP, 16'h0000, 16'h0000};
      rows[4]  = {1'b0, OFS_LEVEL, 16'h0000, 16'h0006};
      rows[5]  = {1'b0, OFS_SN_UPPER, 16'h0000, SN_UPPER};
      rows[6]  = {1'b0, OFS_SN_LOWER, 16'h0000, SN_LOWER};
      rows[7]  = {1'b1, OFS_LINE_CFG, 16'h0002, 16'h0002};
      rows[8]  = {1'b1, OFS_LINE_CFG, 16'h0003, 16'h0002};
      rows[9]  = {1'b1, OFS_STOP, 16'h0001, 16'h0001};
      rows[10] = {1'b1, OFS_SN_UPPER, 16'h1234, SN_UPPER};
      rows[11] = {1'b1, OFS_SLEEP_SEL, 16'h0008, 16'h0008};
      rows[12] = {1'b1, OFS_SLEEP_SEL, 16'h0009, 16'h0008};
      rows[13] = {1'b1, OFS_SLEEP_SEL, 16'h0002, 16'h0008};
      rows[14] = {1'b1, OFS_SLEEP_SEL, 16'h0000, 16'h0000};
      rows[15] = {1'b1, OFS_IDLE, 16'h000F, 16'h0064};
      rows[16] = {1'b1, OFS_IDLE, 16'h0010, 16'h0010};
      rows[17] = {1'b1, 12'h200, 16'h0005, 16'h0000};
      rows[18] = {1'b0, OFS_STATUS, 16'h0000, 16'h0010};
      rows[19] = {1'b1, OFS_STATUS, 16'h0010, 16'h0000};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         if (rows[i][44]) bus(1'b1, rows[i][43:32], {16'h0000, rows[i][31:16]}, rd);
         bus(1'b0, rows[i][43:32], 32'h0000_0000, rd);
         chk("register row", {16'h0000, rows[i][15:0]}, rd);
         chkb("hresp", 1'b0, hresp);
      end
      chkb("stop_two_q", 1'b1, stop_two_q);
      line_in <= 1'b1;
      for (int c = 0; c < 3; c++) begin
         bus(1'b1, OFS_LINE_CFG, c, rd);
         repeat (4) @(posedge clk);
         chkb("rts_hold_q", c == 2, rts_hold_q);
         chkb("bin_prog_q", c == 1, bin_prog_q);
      end
      level_chk(8'h20, 8'h20);
      level_chk(8'h50, 8'h36);
      level_chk(8'h01, 8'h06);
      pin_sleep <= 1'b1;
      wait_on(0, 200, n);
      chk("cycles awake", 200, n);
      bus(1'b1, OFS_SLEEP_SEL, 32'h0000_0001, rd);
      wait_on(0, 10, n);
      chkb("pin sleep", 1'b1, n < 10);
      pin_sleep <= 1'b0;
      repeat (5) @(posedge clk);
      chkb("pin wake", 1'b0, low_power_q);
      wait_on(0, 250, n);
      chk("idle ignored", 250, n);
      i_rmps_radio_model.busy(1'b1, 1'b0);
      bus(1'b1, OFS_SLEEP_SEL, 32'h0000_0003, rd);
      wait_on(0, 300, n);
      chk("tx busy awake", 300, n);
      i_rmps_radio_model.busy(1'b0, 1'b1);
      wait_on(0, 200, n);
      chk("rx busy awake", 200, n);
      i_rmps_radio_model.busy(1'b0, 1'b0);
      wait_on(0, 250, n);
      chkb("idle span", 1'b1, n >= 150 && n <= 172);
      wait_on(1, 80, n);
      chkb("wake period", 1'b1, n >= 45 && n <= 52);
      wait_on(3, 20, n);
      chkb("listen end", 1'b1, n <= 12);
      chkb("back asleep", 1'b1, low_power_q);
      wait_on(1, 80, n);
      chkb("second wake", 1'b1, n >= 45 && n <= 52);
      i_rmps_radio_model.detect();
      repeat (2) @(posedge clk);
      chkb("listen on detect", 1'b0, listen_q);
      i_rmps_radio_model.done();
      wait_on(2, 5, n);
      chkb("rx start", 1'b1, n < 5);
      bus(1'b1, OFS_SLEEP_SEL, 32'h0000_0004, rd);
      wait_on(0, 250, n);
      chkb("idle span sel 4", 1'b1, n >= 145 && n <= 172);
      wait_on(1, 130, n);
      chkb("wake period sel 4", 1'b1, n >= 95 && n <= 102);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, OFS_IDLE, 32'h0000_0000, rd);
      chk("idle after reset", 32'h0000_0064, rd);
      bus(1'b0, OFS_SLEEP_SEL, 32'h0000_0000, rd);
      chk("sel after reset", 32'h0000_0000, rd);
      end_of_test();
   end
endmodule
